// ==== common/dhp_pkg.sv ====
package dhp_pkg;
   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int WADDR_W = 4;
   localparam int IRQ_W = 8;
   localparam int CNT_W = 6;
   localparam int SYNC_W = 5;

   // ---------------------------------------------------------------
   // Synchroniser bit positions and idle values
   // ---------------------------------------------------------------
   localparam int SB_RD = 0;
   localparam int SB_WR = 1;
   localparam int SB_CS = 2;
   localparam int SB_ALE = 3;
   localparam int SB_TRIG = 4;
   // Strobes idle high, trigger idle low
   localparam logic [SYNC_W-1:0] SYNC_RST = 5'h0F;

   // ---------------------------------------------------------------
   // Map and reset values
   // ---------------------------------------------------------------
   localparam logic [WADDR_W-1:0] INT_STATUS_WADDR = 4'h3;
   localparam logic [ADDR_W-1:0] RST_ADDR = 5'h00;
   localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
   localparam logic [IRQ_W-1:0] RST_IRQ = 8'h00;
   localparam logic [CNT_W-1:0] FIFO_EMPTY = 6'h00;
   localparam logic [1:0] BE_LOW = 2'h1;
   localparam logic [1:0] BE_HIGH = 2'h2;
   localparam logic [1:0] BE_BOTH = 2'h3;
endpackage

// ==== common/dhp_strobe_if.sv ====
`timescale 1ns/1ps
interface dhp_strobe_if;
   import dhp_pkg::*;
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] clean;
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// ==== dv/daq_host_bus_port_tb_top.sv ====
`timescale 1ns/1ps
module daq_host_bus_port_tb_top;
   import dhp_pkg::*;
   logic sys_clk_i, resetn_i, bw, cs_n, rd_n, wr_n, ale, hd_en, tb_trig, trig_o, trig_oe;
   logic int_n, dma, reg_rd, reg_wr, trig_dir, c_start, c_done, halt, cap, beg;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] din, dout, hd, wdata, rdata;
   logic [1:0] oe, be;
   logic [WADDR_W-1:0] waddr;
   logic [IRQ_W-1:0] irq, int_en;
   logic [CNT_W-1:0] thr, cnt;
   logic [21:0] wq[$];
   int err_total = 0;
   int num_checks = 0;
   int ncap = 0;
   int nbeg = 0;
   int nrd = 0;
   int k;

   // -------------------------------------------------------------
   // Wires, clock and the device's inner side
   // -------------------------------------------------------------
   assign din = hd_en ? hd : {oe[1] ? dout[15:8] : hd[15:8], oe[0] ? dout[7:0] : hd[7:0]};
   assign rdata = {waddr, 4'h9, ~waddr, 4'h6};
   initial
   begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   dhp_host_port i_dhp_host_port (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .bus_width_select_i(bw), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .ale_i(ale),
      .address_lines_i(addr), .data_lines_i(din), .data_lines_o(dout), .data_lines_oe_o(oe),
      .trig_i(trig_oe ? trig_o : tb_trig), .trig_o(trig_o), .trig_oe_o(trig_oe),
      .int_n_o(int_n), .dma_request_o(dma), .reg_addr_o(waddr), .reg_rd_o(reg_rd),
      .reg_wr_o(reg_wr), .reg_be_o(be), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
      .irq_cond_i(irq), .int_enable_i(int_en), .dma_threshold_i(thr), .fifo_count_i(cnt),
      .trig_dir_i(trig_dir), .conv_start_i(c_start), .conv_done_i(c_done),
      .clk_halt_o(halt), .capture_o(cap), .conv_begin_o(beg));

   dhp_host_model i_dhp_host_model (.sys_clk_i(sys_clk_i), .bus_i(din), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .ale_o(ale), .addr_o(addr), .data_o(hd),
      .data_en_o(hd_en));

   // -------------------------------------------------------------
   // Model and checking
   // -------------------------------------------------------------
   function automatic int exp_rd(int a, int b8);
      int w;
      int f;
      w = (a >> 1) & 15;
      f = (w << 12) | 16'h0906 | ((15 - w) << 4);
      if (b8 != 0)
         f = (f >> ((a & 1) * 8)) & 255;
      return f;
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   always @(posedge sys_clk_i)
   begin
      if (reg_wr === 1'b1)
         wq.push_back({waddr, be, wdata});
      if (cap === 1'b1)
         ncap++;
      if (beg === 1'b1)
         nbeg++;
      if (reg_rd === 1'b1)
         nrd++;
      if (bw === 1'b1 && oe[1] !== 1'b0)
         chk("upper_lane", 0, oe[1]);
   end

   task automatic xfer(input logic wr, input logic b8, input logic [ADDR_W-1:0] a,
                       input logic lat);
      logic [DATA_W-1:0] d;
      logic [DATA_W-1:0] q;
      d = 16'($urandom);
      bw <= b8;
      wq.delete();
      nrd = 0;
      if (lat)
         i_dhp_host_model.latch(a);
      i_dhp_host_model.acc(wr, 1'b1, a, d, q);
      chk("rd_count", wr ? 0 : 1, nrd);
      if (wr)
      begin
         chk("wr_count", 1, wq.size());
         if (wq.size() > 0)
            chk("wr", {10'h000, a[4:1], b8 ? (a[0] ? BE_HIGH : BE_LOW) : BE_BOTH,
                b8 ? {d[7:0], d[7:0]} : d}, wq.pop_front());
      end
      else
         chk("rd", exp_rd(a, b8), b8 ? {8'h00, q[7:0]} : q);
      chk("oe_off", 0, oe);
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      err_total++;
      end_sim();
   end

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial
   begin
      logic [DATA_W-1:0] q;
      resetn_i = 1'b0;
      {bw, tb_trig, trig_dir, c_start, c_done} = 5'h00;
      {irq, int_en, thr, cnt} = 28'h0000000;
      void'($urandom(32'h36b39e84));
      repeat (3) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      chk("rst_pins", 3'h4, {int_n, dma, trig_oe});
      for (int i = 0; i < 8; i++)
         xfer(i[0], i[1], 5'($urandom), i[2]);
      wq.delete();
      i_dhp_host_model.acc(1'b1, 1'b0, 5'($urandom), 16'hA5C3, q);
      chk("wr_unselected", 0, wq.size());
      k = $urandom_range(7);
      int_en <= 8'h01 << k;
      irq <= 8'h01 << k;
      @(posedge sys_clk_i);
      irq <= 8'h00;
      repeat (3) @(posedge sys_clk_i);
      chk("int_set", 0, int_n);
      xfer(1'b0, 1'b0, 5'h06, 1'b0);
      chk("int_clear", 1, int_n);
      int_en <= ~(8'h01 << k);
      irq <= 8'h01 << k;
      repeat (4) @(posedge sys_clk_i);
      chk("int_masked", 1, int_n);
      k = $urandom_range(32, 2);
      thr <= 6'(k);
      cnt <= 6'(k);
      repeat (3) @(posedge sys_clk_i);
      chk("dma_set", 1, dma);
      cnt <= 6'(k - 1);
      repeat (3) @(posedge sys_clk_i);
      chk("dma_hold", 1, dma);
      cnt <= 6'h00;
      repeat (3) @(posedge sys_clk_i);
      chk("dma_clear", 0, dma);
      i_dhp_host_model.sel(1'b1);
      tb_trig <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      chk("halt_cap_beg", {1'b1, 8'h01, 8'h00}, {halt, 8'(ncap), 8'(nbeg)});
      i_dhp_host_model.sel(1'b0);
      tb_trig <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      chk("conv_begin", 1, nbeg);
      tb_trig <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      chk("trig_free", 16'h0202, {8'(ncap), 8'(nbeg)});
      tb_trig <= 1'b0;
      trig_dir <= 1'b1;
      c_start <= 1'b1;
      @(posedge sys_clk_i);
      c_start <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk("trig_start", 2'h3, {trig_oe, trig_o});
      c_done <= 1'b1;
      @(posedge sys_clk_i);
      c_done <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk("trig_done", 2'h2, {trig_oe, trig_o});
      chk("trig_no_cap", 2, ncap);
      end_sim();
   end
endmodule

// ==== dv/dhp_host_model.sv ====
`timescale 1ns/1ps
module dhp_host_model
   import dhp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic [DATA_W-1:0] bus_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic ale_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] data_o,
   output logic data_en_o
);
   // -------------------------------------------------------------
   // Idle bus
   // -------------------------------------------------------------
   // latch strobe high
   initial
   begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      ale_o = 1'b1;
      addr_o = 5'h00;
      data_o = 16'h0000;
      data_en_o = 1'b0;
   end

   // -------------------------------------------------------------
   // Accesses
   // -------------------------------------------------------------
   // select only around access
   task automatic acc(input logic wr, input logic on, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      @(posedge sys_clk_i);
      if (ale_o)
      begin
         cs_n_o <= ~on;
         addr_o <= a;
      end
      data_o <= d;
      data_en_o <= wr;
      repeat (6) @(posedge sys_clk_i);
      rd_n_o <= wr;
      wr_n_o <= ~wr;
      // Strobe width and hold times are long against the 4 ns clock
      repeat (26) @(posedge sys_clk_i);
      q = bus_i;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      cs_n_o <= 1'b1;
      ale_o <= 1'b1;
      addr_o <= ~addr_o;
      data_o <= ~data_o;
      data_en_o <= 1'b0;
      repeat (36) @(posedge sys_clk_i);
   endtask

   // Multiplexed cycle: pins wander once the strobe has fallen
   task automatic latch(input logic [ADDR_W-1:0] a);
      @(posedge sys_clk_i);
      cs_n_o <= 1'b0;
      addr_o <= a;
      repeat (4) @(posedge sys_clk_i);
      ale_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      cs_n_o <= 1'b1;
      addr_o <= ~a;
   endtask

   task automatic sel(input logic v);
      @(posedge sys_clk_i);
      cs_n_o <= ~v;
   endtask
endmodule

// ==== hdl/dhp_host_port.sv ====
// Operation
// R1 - Byte mode: upper lanes float, low byte used
// R2 - Drive data only while read and select low
// R3 - Take data only while write and select low
// R4 - Host selects only during an access
// R5 - Select low halts clocking, suspends conversion
// R6 - Latch strobe falling captures address and select
// R7 - Latch strobe low: address pins ignored
// R8 - Non-multiplexed host holds latch strobe high
// R9 - Five address lines reach every location
// R10 - Trigger input rising edge holds sample
// R11 - Conversion begins on next clock edge
// R12 - Trigger output high at start, low done
// R13 - Reset makes trigger pin an input
// R14 - Unmasked condition asserts low interrupt output
// R15 - Status read clears pending, releases interrupt
// R16 - DMA request when FIFO count equals threshold
// R17 - DMA request drops when FIFO empty
// R18 - Word address upper lines; byte mode uses all
// R19 - Strobes synchronised before touching state
`timescale 1ns/1ps
module dhp_host_port
   import dhp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic bus_width_select_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic ale_i,
   input wire logic [ADDR_W-1:0] address_lines_i,
   input wire logic [DATA_W-1:0] data_lines_i,
   output logic [DATA_W-1:0] data_lines_o,
   output logic [1:0] data_lines_oe_o,
   input wire logic trig_i,
   output logic trig_o,
   output logic trig_oe_o,
   output logic int_n_o,
   output logic dma_request_o,
   output logic [WADDR_W-1:0] reg_addr_o,
   output logic reg_rd_o,
   output logic reg_wr_o,
   output logic [1:0] reg_be_o,
   output logic [DATA_W-1:0] reg_wdata_o,
   input wire logic [DATA_W-1:0] reg_rdata_i,
   input wire logic [IRQ_W-1:0] irq_cond_i,
   input wire logic [IRQ_W-1:0] int_enable_i,
   input wire logic [CNT_W-1:0] dma_threshold_i,
   input wire logic [CNT_W-1:0] fifo_count_i,
   input wire logic trig_dir_i,
   input wire logic conv_start_i,
   input wire logic conv_done_i,
   output logic clk_halt_o,
   output logic capture_o,
   output logic conv_begin_o
);
   // ---------------------------------------------------------------
   // Strobe synchronisers
   // ---------------------------------------------------------------
   dhp_strobe_if sb ();

   assign sb.raw = {trig_i, ale_i, cs_n_i, wr_n_i, rd_n_i};

   // R19 strobe synchronising
   dhp_sync_bank u_sync (
      .sys_clk_i (sys_clk_i),
      .resetn_i (resetn_i),
      .sb (sb)
   );

   wire rd_n_s = sb.clean[SB_RD];
   wire wr_n_s = sb.clean[SB_WR];
   wire cs_n_s = sb.clean[SB_CS];
   wire ale_s = sb.clean[SB_ALE];
   wire trig_s = sb.clean[SB_TRIG];

   // ---------------------------------------------------------------
   // Address latch and decode
   // ---------------------------------------------------------------
   logic [ADDR_W-1:0] addr_lat;
   logic cs_n_lat;
   logic rd_act_q;
   logic wr_act_q;
   logic trig_q;
   logic begin_pend;
   logic [IRQ_W-1:0] pend;

   // R6 R7 transparent while high, held while low
   wire [ADDR_W-1:0] addr_eff = ale_s ? address_lines_i : addr_lat;
   wire cs_n_eff = ale_s ? cs_n_s : cs_n_lat;
   wire bw = bus_width_select_i;
   // R9 R18 word index from upper lines, byte lane from A0
   wire [WADDR_W-1:0] word_addr = addr_eff[ADDR_W-1:1];
   wire byte_hi = bw & addr_eff[0];

   // R2 R3 access qualified by select
   wire rd_act = ~rd_n_s & ~cs_n_eff;
   wire wr_act = ~wr_n_s & ~cs_n_eff;
   wire rd_start = rd_act & ~rd_act_q;
   wire wr_end = ~wr_act & wr_act_q;
   wire status_rd = rd_start & (word_addr == INT_STATUS_WADDR);

   // R1 byte mode reads place the selected byte on the low lane
   wire [DATA_W-1:0] rd_fmt = !bw ? reg_rdata_i :
                              byte_hi ? {8'h00, reg_rdata_i[15:8]} :
                              {8'h00, reg_rdata_i[7:0]};
   wire [DATA_W-1:0] wr_fmt = bw ? {data_lines_i[7:0], data_lines_i[7:0]} : data_lines_i;
   wire [1:0] wr_be = !bw ? BE_BOTH : (byte_hi ? BE_HIGH : BE_LOW);

   // ---------------------------------------------------------------
   // Trigger, interrupt and DMA terms
   // ---------------------------------------------------------------
   // R10 only an input pin can trigger
   wire trig_rise = trig_s & ~trig_q & ~trig_dir_i;
   // R5 select low stops conversion activity
   wire halted = ~cs_n_s;
   wire [IRQ_W-1:0] irq_new = irq_cond_i & int_enable_i;
   // R15 clear on status read, new event still wins
   wire [IRQ_W-1:0] next_pend = (status_rd ? RST_IRQ : pend) | irq_new;
   wire fifo_empty = (fifo_count_i == FIFO_EMPTY);
   wire dma_hit = (fifo_count_i == dma_threshold_i);

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         addr_lat <= RST_ADDR;
         cs_n_lat <= 1'b1;
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
      end
      else
      begin
         // R6 last value before the fall is kept
         if (ale_s)
         begin
            addr_lat <= address_lines_i;
            cs_n_lat <= cs_n_s;
         end
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
      end
   end

   // ---------------------------------------------------------------
   // Data path
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         data_lines_o <= RST_DATA;
         data_lines_oe_o <= 2'h0;
         reg_addr_o <= INT_STATUS_WADDR;
         reg_rd_o <= 1'b0;
         reg_wr_o <= 1'b0;
         reg_be_o <= BE_BOTH;
         reg_wdata_o <= RST_DATA;
      end
      else
      begin
         data_lines_o <= rd_fmt;
         // R2 R1 drive low lane on read, upper only in word mode
         data_lines_oe_o <= {rd_act & ~bw, rd_act};
         reg_addr_o <= word_addr;
         reg_rd_o <= rd_start;
         // R3 sample bus only inside an active write
         if (wr_act)
         begin
            reg_wdata_o <= wr_fmt;
            reg_be_o <= wr_be;
         end
         reg_wr_o <= wr_end;
      end
   end

   // ---------------------------------------------------------------
   // Trigger pin, interrupt, DMA
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         trig_q <= 1'b0;
         trig_o <= 1'b0;
         // R13 pin comes up as an input
         trig_oe_o <= 1'b0;
         capture_o <= 1'b0;
         begin_pend <= 1'b0;
         conv_begin_o <= 1'b0;
         clk_halt_o <= 1'b0;
         pend <= RST_IRQ;
         int_n_o <= 1'b1;
         dma_request_o <= 1'b0;
      end
      else
      begin
         trig_q <= trig_s;
         trig_oe_o <= trig_dir_i;
         // R12 output follows conversion start and end
         if (!trig_dir_i)
            trig_o <= 1'b0;
         else if (conv_start_i)
            trig_o <= 1'b1;
         else if (conv_done_i)
            trig_o <= 1'b0;
         // R10 hold pulse on rising edge
         capture_o <= trig_rise;
         // R11 start waits for the next unhalted edge
         begin_pend <= trig_rise | (begin_pend & halted);
         conv_begin_o <= begin_pend & ~halted;
         clk_halt_o <= halted;
         // R14 any unmasked pending drives interrupt low
         pend <= next_pend;
         int_n_o <= ~|pend;
         // R16 R17 set on threshold, clear on empty
         if (fifo_empty)
            dma_request_o <= 1'b0;
         else if (dma_hit)
            dma_request_o <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_read_held;
      rd_act [*2];
   endsequence

   sequence s_trig_seen;
      capture_o && !halted;
   endsequence

   property p_upper_float;
      bw && $past(bw) |-> !data_lines_oe_o[1];
   endproperty
   a_upper_float: assert property (p_upper_float) else $error("upper lane driven in byte mode"); // R1
   property p_read_drive;
      s_read_held |-> data_lines_oe_o[0] && (data_lines_oe_o[1] != $past(bw));
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read lane not driven"); // R2
   property p_no_drive_idle;
      !rd_act |=> !data_lines_oe_o[0] && !data_lines_oe_o[1];
   endproperty
   a_no_drive_idle: assert property (p_no_drive_idle) else $error("bus driven outside read"); // R2
   property p_write_qual;
      reg_wr_o |-> $past(wr_act, 2) && !$past(wr_act, 1);
   endproperty
   a_write_qual: assert property (p_write_qual) else $error("write pulse without access"); // R3
   property p_halt;
      !cs_n_s |=> clk_halt_o && !conv_begin_o;
   endproperty
   a_halt: assert property (p_halt) else $error("not halted while selected"); // R5

   property p_ale_capture;
      $fell(ale_s) |-> addr_lat == $past(address_lines_i);
   endproperty
   a_ale_capture: assert property (p_ale_capture) else $error("address not captured"); // R6

   property p_ale_hold;
      !ale_s && !$past(ale_s) |-> $stable(addr_lat) && $stable(cs_n_lat);
   endproperty
   a_ale_hold: assert property (p_ale_hold) else $error("latched address changed"); // R7

   property p_trig_begin;
      s_trig_seen |=> conv_begin_o;
   endproperty
   a_trig_begin: assert property (p_trig_begin) else $error("conversion did not begin"); // R11

   property p_trig_out;
      trig_dir_i && conv_start_i |=> trig_o && trig_oe_o;
   endproperty
   a_trig_out: assert property (p_trig_out) else $error("trigger output not raised"); // R12

   property p_irq_assert;
      |irq_new |-> ##2 !int_n_o;
   endproperty
   a_irq_assert: assert property (p_irq_assert) else $error("interrupt not asserted"); // R14

   property p_irq_clear;
      status_rd && !(|irq_new) ##1 !(|irq_new) |-> ##1 int_n_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt not released"); // R15

   property p_dma_set;
      dma_hit && !fifo_empty |=> dma_request_o;
   endproperty
   a_dma_set: assert property (p_dma_set) else $error("dma request not raised"); // R16

   property p_dma_clear;
      fifo_empty |=> !dma_request_o;
   endproperty
   a_dma_clear: assert property (p_dma_clear) else $error("dma request not dropped"); // R17
endmodule

// ==== hdl/dhp_sync_bank.sv ====
`timescale 1ns/1ps
module dhp_sync_bank
   import dhp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   dhp_strobe_if.sync sb
);
   logic [SYNC_W-1:0] meta;
   logic [SYNC_W-1:0] stage;

   // ---------------------------------------------------------------
   // Two flops per pin
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++)
      begin : g_bit
         always_ff @(posedge sys_clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
            begin
               meta[gi] <= SYNC_RST[gi];
               stage[gi] <= SYNC_RST[gi];
            end
            else
            begin
               meta[gi] <= sb.raw[gi];
               stage[gi] <= meta[gi];
            end
         end
      end
   endgenerate

   assign sb.clean = stage;

   property p_sync_delay;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      ##2 (stage == $past(sb.raw, 2));
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sync delay not two cycles"); // R19
endmodule
